// ==== logic/plm_pkg.sv ====
// constants, types and register map of the low port pin function mux
// ==========================================================================
// What this block does
// R1: a pin change on a wake-enabled digital pin raises a wake-up request
// R2: per-pin direction bit picks push-pull output or Schmitt input
// R3: pull-high enable follows its register bit unless the pin is analog
// R4: analog use of each pin is enabled only by a software register write
// R5: pin zero analog: digital path and pull-high turned off
// R6: pin one analog: digital path, frequency output and pull-high turned off
// R7: pin one digital: control bit picks frequency output or plain port
// R8: pin two feeds the timer count input unless analog; it is channel two
// R9: pin two analog: digital path, timer input and pull-high turned off
// R10: with frequency output selected, pin one drives the generator value
package plm_pkg;
   localparam int          NPIN        = 3;
   localparam int          AW          = 8;
   // ========================================================================
   // register byte addresses, one aligned 32-bit word each
   localparam logic [7:0]  OFS_LATCH   = 8'h00;
   localparam logic [7:0]  OFS_DIR     = 8'h04;
   localparam logic [7:0]  OFS_PULL    = 8'h08;
   localparam logic [7:0]  OFS_WAKE    = 8'h0C;
   localparam logic [7:0]  OFS_ANA     = 8'h10;
   localparam logic [7:0]  OFS_CTRL0   = 8'h14;
   localparam logic [7:0]  OFS_PINS    = 8'h18;
   // ========================================================================
   // reset values and field positions
   localparam logic [2:0]  RST_LATCH   = 3'h0;
   localparam logic [2:0]  RST_DIR     = 3'h7;
   localparam logic [2:0]  RST_PULL    = 3'h0;
   localparam logic [2:0]  RST_WAKE    = 3'h0;
   localparam logic [2:0]  RST_ANA     = 3'h0;
   localparam logic        RST_PFD     = 1'b0;
   localparam int          CTRL_PFD    = 0;
   localparam int          PIN_PFD     = 1;
   localparam int          PIN_TMR     = 2;
   localparam logic [31:0] RD_ZERO     = 32'h0000_0000;
   // ========================================================================
   // software-visible configuration, carried as one bundle
   typedef struct packed {
      logic [2:0] latch;
      logic [2:0] dir;   // 1 = input
      logic [2:0] pull;
      logic [2:0] wake;
      logic [2:0] ana;
      logic       pfd_sel;
   } plm_cfg_t;
   // registered pad-side drive of all pins
   typedef struct packed {
      logic [2:0] out;
      logic [2:0] oe_n;
      logic [2:0] pull_en;
   } plm_pad_t;
endpackage

// ==== logic/plm_sync.sv ====
// two-flop synchroniser for the port pin inputs
`timescale 1ns/1ps
module plm_sync #(
   parameter int W = 3
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;
   // ========================================================================
   // one pair of flops per pin; the first flop feeds only the second
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            meta_r[i] <= 1'b0;
            q_r[i]    <= 1'b0;
         end else begin
            meta_r[i] <= d[i];
            q_r[i]    <= meta_r[i];
         end
      end
   end
   assign q = q_r;
endmodule // plm_sync

// ==== logic/plm_mux.sv ====
// top of the low port pin function mux with its wishbone register slave
`timescale 1ns/1ps
module plm_mux (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [2:0]  port_pin_in,
   output logic      [2:0]  port_pin_out,
   output logic      [2:0]  port_pin_oe_n,
   output logic      [2:0]  pull_high_en,
   output logic      [2:0]  analog_sel,
   input  wire logic        freq_gen_output,
   output logic             timer_zero_ext_input,
   output logic             wake_req
);
   plm_pkg::plm_cfg_t cfg_r, cfg_nxt;
   plm_pkg::plm_pad_t pad_r, pad_nxt;
   logic [31:0]       rdat_r, rdat_nxt;
   logic              ack_r, ack_nxt;
   logic [2:0]        pin_s;
   logic [2:0]        pin_prev_r, pin_prev_nxt;
   logic [2:0]        ana_r, ana_nxt;
   logic              tmr_r, tmr_nxt;
   logic              wake_r, wake_nxt;
   logic              req, wr;
   logic              ana_wr;
   logic [2:0]        din;

   // ========================================================================
   // pin input synchronisers
   plm_sync #(.W(plm_pkg::NPIN)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   (port_pin_in),
      .q   (pin_s)
   );

   // ========================================================================
   // wishbone slave: ack one cycle after the request, low the cycle after
   assign req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr  = req & wb_we_i & wb_sel_i[0];
   // strobe of a software write to the analog select word
   assign ana_wr = wr & (wb_adr_i == plm_pkg::OFS_ANA);

   always_comb begin
      cfg_nxt  = cfg_r;
      ack_nxt  = req;
      rdat_nxt = plm_pkg::RD_ZERO;
      if (wr) begin
         case (wb_adr_i)
            plm_pkg::OFS_LATCH: cfg_nxt.latch   = wb_dat_i[2:0];
            plm_pkg::OFS_DIR:   cfg_nxt.dir     = wb_dat_i[2:0];
            plm_pkg::OFS_PULL:  cfg_nxt.pull    = wb_dat_i[2:0];
            plm_pkg::OFS_WAKE:  cfg_nxt.wake    = wb_dat_i[2:0];
            plm_pkg::OFS_ANA:   cfg_nxt.ana     = wb_dat_i[2:0];     // [R4]
            plm_pkg::OFS_CTRL0: cfg_nxt.pfd_sel = wb_dat_i[plm_pkg::CTRL_PFD];
            default: ;
         endcase
      end
      if (req & ~wb_we_i) begin
         case (wb_adr_i)
            plm_pkg::OFS_LATCH: rdat_nxt[2:0] = cfg_r.latch;
            plm_pkg::OFS_DIR:   rdat_nxt[2:0] = cfg_r.dir;
            plm_pkg::OFS_PULL:  rdat_nxt[2:0] = cfg_r.pull;
            plm_pkg::OFS_WAKE:  rdat_nxt[2:0] = cfg_r.wake;
            plm_pkg::OFS_ANA:   rdat_nxt[2:0] = cfg_r.ana;
            plm_pkg::OFS_CTRL0: rdat_nxt[plm_pkg::CTRL_PFD] = cfg_r.pfd_sel;
            plm_pkg::OFS_PINS:  rdat_nxt[2:0] = din;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_r.latch   <= plm_pkg::RST_LATCH;
         cfg_r.dir     <= plm_pkg::RST_DIR;
         cfg_r.pull    <= plm_pkg::RST_PULL;
         cfg_r.wake    <= plm_pkg::RST_WAKE;
         cfg_r.ana     <= plm_pkg::RST_ANA;
         cfg_r.pfd_sel <= plm_pkg::RST_PFD;
         ack_r         <= 1'b0;
         rdat_r        <= plm_pkg::RD_ZERO;
      end else begin
         cfg_r  <= cfg_nxt;
         ack_r  <= ack_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   // ========================================================================
   // pin function mux; analog selection overrides every digital function
   // digital input reads as zero on an analog pin so the schmitt path is off
   assign din = pin_s & ~cfg_r.ana;

   always_comb begin
      pad_nxt      = '{out: cfg_r.latch, oe_n: cfg_r.dir, pull_en: cfg_r.pull}; // [R2] [R3]
      ana_nxt      = cfg_r.ana;
      pin_prev_nxt = pin_s;
      // frequency output drives pin one regardless of its direction bit
      if (cfg_r.pfd_sel) begin                                  // [R7]
         pad_nxt.out[plm_pkg::PIN_PFD]  = freq_gen_output;      // [R10]
         pad_nxt.oe_n[plm_pkg::PIN_PFD] = 1'b0;
      end
      for (int i = 0; i < plm_pkg::NPIN; i++) begin
         if (cfg_r.ana[i]) begin                                // [R5] [R6] [R9]
            pad_nxt.out[i]     = 1'b0;
            pad_nxt.oe_n[i]    = 1'b1;
            pad_nxt.pull_en[i] = 1'b0;
         end
      end
      tmr_nxt  = din[plm_pkg::PIN_TMR];                          // [R8] [R9]
      // only digital pins can wake; an analog level would chatter
      // raw levels are compared so an analog switch on a high pin is no change
      wake_nxt = |((pin_s ^ pin_prev_r) & cfg_r.wake & ~cfg_r.ana); // [R1]
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pad_r      <= '{out: plm_pkg::RST_LATCH, oe_n: plm_pkg::RST_DIR,
                         pull_en: plm_pkg::RST_PULL};
         ana_r      <= plm_pkg::RST_ANA;
         pin_prev_r <= 3'h0;
         tmr_r      <= 1'b0;
         wake_r     <= 1'b0;
      end else begin
         pad_r      <= pad_nxt;
         ana_r      <= ana_nxt;
         pin_prev_r <= pin_prev_nxt;
         tmr_r      <= tmr_nxt;
         wake_r     <= wake_nxt;
      end
   end

   assign wb_dat_o             = rdat_r;
   assign wb_ack_o             = ack_r;
   assign port_pin_out         = pad_r.out;
   assign port_pin_oe_n        = pad_r.oe_n;
   assign pull_high_en         = pad_r.pull_en;
   assign analog_sel           = ana_r;
   assign timer_zero_ext_input = tmr_r;
   assign wake_req             = wake_r;

   // ========================================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_wb_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_wb_ans;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   sequence s_wake_edge;
      (|((pin_s ^ pin_prev_r) & cfg_r.wake & ~cfg_r.ana));
   endsequence
   sequence s_rd_pins;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == plm_pkg::OFS_PINS;
   endsequence

   chk_bus_ack_pulse: assert property (s_wb_req |=> s_wb_ans)
      else $error("ack not a single pulse after request");
   chk_ana_by_write: assert property (                             // [R4]
      $changed(analog_sel) |-> $past(ana_wr, 2))
      else $error("analog select changed without a write");
   chk_pin0_analog: assert property (cfg_r.ana[0] |=>              // [R5]
      port_pin_oe_n[0] && !pull_high_en[0])
      else $error("pin zero analog still digital");
   chk_pin1_analog: assert property (cfg_r.ana[1] |=>              // [R6]
      port_pin_oe_n[1] && !pull_high_en[1] && !port_pin_out[1])
      else $error("pin one analog still driven");
   chk_pfd_drive: assert property (cfg_r.pfd_sel && !cfg_r.ana[1] |=> // [R7]
      !port_pin_oe_n[1] && port_pin_out[1] == $past(freq_gen_output))
      else $error("frequency output not on pin one");
   chk_dir_drive: assert property (!cfg_r.ana[0] |=>               // [R2]
      port_pin_oe_n[0] == $past(cfg_r.dir[0]) && port_pin_out[0] == $past(cfg_r.latch[0]))
      else $error("pin zero drive mismatch");
   chk_pull_follow: assert property (cfg_r.pull[2] && !cfg_r.ana[2] |=> // [R3]
      pull_high_en[2])
      else $error("pull-high not applied");
   chk_timer_feed: assert property (##1 timer_zero_ext_input ==    // [R8] [R9]
      ($past(pin_s[2]) && !$past(cfg_r.ana[2])))
      else $error("timer input wrong");
   chk_wake_pulse: assert property (s_wake_edge |=> wake_req)      // [R1]
      else $error("wake request missed");
   chk_wake_quiet: assert property (                               // [R1]
      !(|((pin_s ^ pin_prev_r) & cfg_r.wake & ~cfg_r.ana)) |=> !wake_req)
      else $error("wake request without a pin change");
   chk_pin2_analog: assert property (cfg_r.ana[2] |=>              // [R9]
      port_pin_oe_n[2] && !pull_high_en[2] && !port_pin_out[2])
      else $error("pin two analog still driven");
   chk_timer_analog: assert property (cfg_r.ana[2] |=>             // [R9]
      !timer_zero_ext_input)
      else $error("timer input live on analog pin");
   chk_pfd_off: assert property (!cfg_r.pfd_sel && !cfg_r.ana[1] |=> // [R7]
      port_pin_oe_n[1] == $past(cfg_r.dir[1]) && port_pin_out[1] == $past(cfg_r.latch[1]))
      else $error("pin one not plain port");
   chk_dir_pin2: assert property (!cfg_r.ana[2] |=>                // [R2]
      port_pin_oe_n[2] == $past(cfg_r.dir[2]) && port_pin_out[2] == $past(cfg_r.latch[2]))
      else $error("pin two drive mismatch");
   chk_pull_pin0: assert property (cfg_r.pull[0] && !cfg_r.ana[0] |=> // [R3]
      pull_high_en[0])
      else $error("pull-high not applied on pin zero");
   chk_status_ana: assert property (s_rd_pins |=>                  // [R5] [R6] [R9]
      (wb_dat_o[2:0] & $past(cfg_r.ana)) == 3'h0)
      else $error("analog pin reads as digital");

   // the bus must not answer unasked, and read data must not leak outside ack
   chk_ack_no_req: assert property (
      !(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> !wb_ack_o)
      else $error("ack without a request");
   chk_rdat_idle: assert property (!wb_ack_o |-> wb_dat_o == plm_pkg::RD_ZERO)
      else $error("read data not zero outside ack");
endmodule // plm_mux

// ==== bench/plm_pad_model.sv ====
// board side of the three low port pins
`timescale 1ns/1ps
module plm_pad_model (
   input  wire logic       clk,
   input  wire logic [2:0] out,
   input  wire logic [2:0] oe_n,
   input  wire logic [2:0] pull_en,
   input  wire logic [2:0] ext_drv,
   input  wire logic [2:0] ext_val,
   output logic      [2:0] pin
);
   // ========================================================================
   // wire level per pin
   // a floating pin toggles each cycle so that a lost pull-up never reads as a clean level
   logic [2:0] flt_r = 3'h0;
   always @(posedge clk) begin
      flt_r <= ~flt_r;
   end
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (!oe_n[i]) pin[i] = out[i];
         else if (ext_drv[i]) pin[i] = ext_val[i];
         else if (pull_en[i]) pin[i] = 1'b1;
         else pin[i] = flt_r[i];
      end
   end
endmodule // plm_pad_model

// ==== bench/plm_mux_test.sv ====
// self-checking bench of the low port pin function mux
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
   $display("BAD %0t value mismatch", $time); end end
module plm_mux_test;
   logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, fg = 0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0000_0000, rdv, v;
   logic [3:0]  sel = 4'h0;
   logic [2:0]  pin, pout, poe_n, pull, ana, ext_drv = 3'h7, ext_val = 3'h0;
   logic        tmr, wake, ack;
   int          mismatches = 0, comparisons = 0, cnt = 0, wk = 0, w0;
   plm_mux i_plm_mux (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdv), .wb_ack_o(ack),
      .port_pin_in(pin), .port_pin_out(pout), .port_pin_oe_n(poe_n), .pull_high_en(pull),
      .analog_sel(ana), .freq_gen_output(fg), .timer_zero_ext_input(tmr), .wake_req(wake));
   plm_pad_model i_plm_pad_model (.clk(clk), .out(pout), .oe_n(poe_n), .pull_en(pull),
      .ext_drv(ext_drv), .ext_val(ext_val), .pin(pin));
   initial begin
      forever #10 clk = ~clk;
   end
   // ========================================================================
   // wake pulse counter and hang guard
   always @(posedge clk) begin
      if (wake === 1'b1) wk <= wk + 1;
      cnt <= cnt + 1;
      if (cnt == 5000) begin
         mismatches++;
         conclude();
      end
   end
   task conclude();
      if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ========================================================================
   // classic wishbone single cycles; ack is taken at the edge where it is seen high
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'h1;
      do @(posedge clk); while (ack !== 1'b1);
      v = rdv;
      cyc <= 0; stb <= 0; we <= 0;
   endtask
   task idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   initial begin
      idle(3);
      rst <= 0;
      bus(0, plm_pkg::OFS_DIR, 32'h0);
      `CHK(v[2:0], plm_pkg::RST_DIR)
      `CHK({poe_n, pull, ana}, 9'h1C0)
      bus(0, 8'h1C, 32'h0);
      `CHK(v, plm_pkg::RD_ZERO)
      ext_drv <= 3'h0;
      bus(1, plm_pkg::OFS_LATCH, 32'h5);
      bus(1, plm_pkg::OFS_DIR, 32'h0);
      idle(5);
      `CHK({pout, poe_n}, 6'h28)
      bus(0, plm_pkg::OFS_PINS, 32'h0);
      `CHK(v[2:0], 3'h5)
      bus(1, plm_pkg::OFS_DIR, 32'h7);
      bus(1, plm_pkg::OFS_PULL, 32'h7);
      idle(5);
      `CHK(pull, 3'h7)
      bus(0, plm_pkg::OFS_PINS, 32'h0);
      `CHK(v[2:0], 3'h7)
      ext_drv <= 3'h4;
      idle(5);
      `CHK(tmr, 1'b0)
      ext_val <= 3'h4;
      idle(5);
      `CHK(tmr, 1'b1)
      bus(1, plm_pkg::OFS_WAKE, 32'h4);
      w0 = wk;
      ext_val <= 3'h0;
      idle(8);
      `CHK(wk - w0, 1)
      bus(1, plm_pkg::OFS_ANA, 32'h7);
      bus(1, plm_pkg::OFS_CTRL0, 32'h1);
      idle(4);
      w0 = wk;
      ext_val <= 3'h4;
      idle(8);
      `CHK(wk - w0, 0)
      `CHK({poe_n, pull, ana, tmr}, 10'h38E)
      bus(0, plm_pkg::OFS_PINS, 32'h0);
      `CHK(v[2:0], 3'h0)
      bus(1, plm_pkg::OFS_LATCH, 32'h7);
      w0 = wk;
      bus(1, plm_pkg::OFS_ANA, 32'h0);
      fg <= 1;
      idle(4);
      `CHK({pout[1], poe_n[1]}, 2'b10)
      fg <= 0;
      idle(3);
      `CHK(pout[1], 1'b0)
      `CHK(wk - w0, 0)
      bus(1, plm_pkg::OFS_CTRL0, 32'h0);
      idle(3);
      `CHK(poe_n[1], 1'b1)
      conclude();
   end
endmodule // plm_mux_test
